// ---- core/mm_capture_input.sv ----
/*
  Input-side logic of multi mode channels 2 and 3: mode select, digital
  input filter and capture prescaler, with one APB control register.
  Assumes raw inputs arrive asynchronously, dts_tick is a one-cycle pulse
  at the dead-time clock rate, and polarity has been applied upstream.
*/
// The address map and the APB slave port were chosen for this implementation.
// What this block does
// [R1] Software changes a mode-select field only while its channel is disabled; such writes are ignored otherwise.
// [R2] Mode code 000 makes channel 2 an output channel, not a capture input.
// [R3] Code 001 captures from the channel's own filtered input and 010 from the neighbour channel's.
// [R4] Code 011 captures from the internal trigger, meaningful only when an internal trigger is selected.
// [R5] Code 100 captures from the plain channel filtered input; codes 101 to 111 are reserved.
// [R6] Mode-select top bits sit at 30 and 31, low bits at 1:0 and 9:8.
// [R7] The filter counts equal samples at the chosen rate and accepts a level on reaching the count; code 0 bypasses.
// [R8] Filter codes select counts 2, 4, 8 at timer clock and 5, 6 or 8 at dts divided by 2 to 32.
// [R9] Prescaler codes 00, 01, 10, 11 capture every 1, 2, 4, 8 active edges.
// [R10] The prescaler edge counter resets while the channel enable bit is clear.
// [R11] Channel 2 filter is at bits 7:4, prescaler at 3:2, low mode bits at 1:0.
// [R12] Channel 3 filter at 15:12 and prescaler at 11:10 behave as channel 2's.
// [R13] Software keeps reserved bits 29:16 at their reset value.
// [R14] A reserved mode code disconnects the channel input so that no capture occurs.
`timescale 1ns/1ps

module mm_capture_input
  import mm_capture_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dts_tick,
  input wire logic chan2_raw_input,
  input wire logic chan3_raw_input,
  input wire logic plain_chan2_raw,
  input wire logic plain_chan3_raw,
  input wire logic internal_trigger_signal,
  input wire logic chan2_enable_bit,
  input wire logic chan3_enable_bit,
  output logic chan2_is_output,
  output logic chan3_is_output,
  output logic chan2_capture_source,
  output logic chan3_capture_source,
  output logic chan2_capture,
  output logic chan3_capture
);

  logic [31:0] ctrl_ff;
  logic [1:0] raw_s1_ff, raw_s2_ff, plain_s1_ff, plain_s2_ff;
  logic [4:0] dts_div_ff;
  logic [1:0] flt_lvl_ff, plain_lvl_ff;
  logic [3:0] flt_cnt_ff [2];
  logic [3:0] plain_cnt_ff [2];
  logic [1:0] src_ff, src_q_ff, cap_ff;
  logic [2:0] psc_cnt_ff [2];
  logic [1:0] is_out_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;

  // APB decode
  wire setup = psel && !penable;
  wire acc_done = psel && penable && pready_ff;
  wire hit_ctrl = paddr == ctrl_offset;
  wire hit_status = paddr == status_offset;
  wire wr_ctrl = acc_done && pwrite && hit_ctrl;
  wire [1:0] ch_en = {chan3_enable_bit, chan2_enable_bit};

  // Field views
  wire [2:0] mode_c2 = {ctrl_ff[c2_ms_hi_pos], ctrl_ff[c2_ms_lo_pos +: 2]}; // see [R6]
  wire [2:0] mode_c3 = {ctrl_ff[c3_ms_hi_pos], ctrl_ff[c3_ms_lo_pos +: 2]}; // see [R6]
  wire [3:0] flt_c2 = ctrl_ff[c2_flt_pos +: 4]; // see [R11]
  wire [3:0] flt_c3 = ctrl_ff[c3_flt_pos +: 4]; // see [R12]
  wire [1:0] psc_c2 = ctrl_ff[c2_psc_pos +: 2]; // see [R11]
  wire [1:0] psc_c3 = ctrl_ff[c3_psc_pos +: 2]; // see [R12]

  // Write merge: mode bits frozen while the channel is active
  wire [31:0] ms_c2_mask = (32'h1 << c2_ms_hi_pos) | (32'h3 << c2_ms_lo_pos);
  wire [31:0] ms_c3_mask = (32'h1 << c3_ms_hi_pos) | (32'h3 << c3_ms_lo_pos);
  wire [31:0] keep_mask = ctrl_rsvd_mask | (chan2_enable_bit ? ms_c2_mask : 32'h0) |
    (chan3_enable_bit ? ms_c3_mask : 32'h0); // see [R1]
  wire [31:0] nxt_ctrl = (ctrl_ff & keep_mask) | (pwdata & ~keep_mask); // see [R13]

  // Status word
  wire [31:0] status_word = (32'(src_ff[0]) << st_c2_lvl_pos) | (32'(src_ff[1]) << st_c3_lvl_pos) |
    (32'(is_out_ff[0]) << st_c2_out_pos) | (32'(is_out_ff[1]) << st_c3_out_pos) |
    (32'(psc_cnt_ff[0]) << st_c2_cnt_pos) | (32'(psc_cnt_ff[1]) << st_c3_cnt_pos);
  wire [31:0] nxt_prdata = hit_ctrl ? ctrl_ff : (hit_status ? status_word : 32'h0);
  wire nxt_slverr = !(hit_ctrl || hit_status) || (pwrite && hit_status);

  // Dead-time divided sample strobes
  wire [5:0] rate_tick = {dts_tick && dts_div_ff == 5'h1f, dts_tick && dts_div_ff[3:0] == 4'hf,
    dts_tick && dts_div_ff[2:0] == 3'h7, dts_tick && dts_div_ff[1:0] == 2'h3,
    dts_tick && dts_div_ff[0], 1'b1};

  // Filter setup per channel
  wire [3:0] flt_code [2];
  assign flt_code[0] = flt_c2;
  assign flt_code[1] = flt_c3;
  wire [1:0] samp;
  wire [1:0] flt_out, plain_out;
  assign samp[0] = rate_tick[flt_rate(flt_c2)]; // see [R8]
  assign samp[1] = rate_tick[flt_rate(flt_c3)]; // see [R8]

  // Bypass when the filter code is zero
  assign flt_out[0] = flt_c2 == 4'h0 ? raw_s2_ff[0] : flt_lvl_ff[0]; // see [R7]
  assign flt_out[1] = flt_c3 == 4'h0 ? raw_s2_ff[1] : flt_lvl_ff[1]; // see [R7]
  assign plain_out[0] = flt_c2 == 4'h0 ? plain_s2_ff[0] : plain_lvl_ff[0];
  assign plain_out[1] = flt_c3 == 4'h0 ? plain_s2_ff[1] : plain_lvl_ff[1];

  // Source multiplexers; reserved codes leave the source idle low
  function automatic logic pick_src(input logic [2:0] mode, input logic own, input logic nbr,
    input logic trg, input logic plain);
    unique case (mode)
      mode_own_input: pick_src = own; // see [R3]
      mode_neighbour_input: pick_src = nbr; // see [R3]
      mode_internal_trigger: pick_src = trg; // see [R4]
      mode_plain_input: pick_src = plain; // see [R5]
      default: pick_src = 1'b0; // see [R2] [R14]
    endcase
  endfunction

  wire [1:0] nxt_src;
  assign nxt_src[0] = pick_src(mode_c2, flt_out[0], flt_out[1], internal_trigger_signal, plain_out[0]);
  assign nxt_src[1] = pick_src(mode_c3, flt_out[1], flt_out[0], internal_trigger_signal, plain_out[1]);
  wire [1:0] valid_in = {mode_c3 != mode_output && mode_c3 <= mode_plain_input,
    mode_c2 != mode_output && mode_c2 <= mode_plain_input}; // see [R14]

  // Rising active edge of the chosen source
  wire [1:0] edge_seen = nxt_src & ~src_q_ff & valid_in;
  wire [2:0] mask_c [2];
  assign mask_c[0] = psc_mask(psc_c2);
  assign mask_c[1] = psc_mask(psc_c3);

  // APB slave: zero-wait single-cycle access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= ctrl_reset;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
        pslverr_ff <= nxt_slverr;
      end
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl; // see [R1]
      end
    end
  end

  // Input synchronisers and dts divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_s1_ff <= 2'b00;
      raw_s2_ff <= 2'b00;
      plain_s1_ff <= 2'b00;
      plain_s2_ff <= 2'b00;
      dts_div_ff <= 5'h0;
    end else if (clk_en) begin
      raw_s1_ff <= {chan3_raw_input, chan2_raw_input};
      raw_s2_ff <= raw_s1_ff;
      plain_s1_ff <= {plain_chan3_raw, plain_chan2_raw};
      plain_s2_ff <= plain_s1_ff;
      if (dts_tick) begin
        dts_div_ff <= dts_div_ff + 5'h1;
      end
    end
  end

  // Per-channel filter, edge detect and prescaler
  for (genvar i = 0; i < 2; i++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flt_lvl_ff[i] <= 1'b0;
        plain_lvl_ff[i] <= 1'b0;
        flt_cnt_ff[i] <= 4'h0;
        plain_cnt_ff[i] <= 4'h0;
      end else if (clk_en && samp[i]) begin
        // Count equal samples differing from accepted level
        if (raw_s2_ff[i] == flt_lvl_ff[i]) begin
          flt_cnt_ff[i] <= 4'h0;
        end else if (flt_cnt_ff[i] + 4'h1 >= flt_count(flt_code[i])) begin
          flt_lvl_ff[i] <= raw_s2_ff[i]; // see [R7]
          flt_cnt_ff[i] <= 4'h0;
        end else begin
          flt_cnt_ff[i] <= flt_cnt_ff[i] + 4'h1;
        end
        if (plain_s2_ff[i] == plain_lvl_ff[i]) begin
          plain_cnt_ff[i] <= 4'h0;
        end else if (plain_cnt_ff[i] + 4'h1 >= flt_count(flt_code[i])) begin
          plain_lvl_ff[i] <= plain_s2_ff[i];
          plain_cnt_ff[i] <= 4'h0;
        end else begin
          plain_cnt_ff[i] <= plain_cnt_ff[i] + 4'h1;
        end
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_q_ff[i] <= 1'b0;
        src_ff[i] <= 1'b0;
        cap_ff[i] <= 1'b0;
        psc_cnt_ff[i] <= 3'h0;
        is_out_ff[i] <= 1'b1;
      end else if (clk_en) begin
        src_q_ff[i] <= nxt_src[i];
        src_ff[i] <= nxt_src[i];
        is_out_ff[i] <= (i == 0 ? mode_c2 : mode_c3) == mode_output; // see [R2]
        cap_ff[i] <= ch_en[i] && edge_seen[i] && psc_cnt_ff[i] == mask_c[i]; // see [R9]
        if (!ch_en[i]) begin
          psc_cnt_ff[i] <= 3'h0; // see [R10]
        end else if (edge_seen[i]) begin
          psc_cnt_ff[i] <= psc_cnt_ff[i] == mask_c[i] ? 3'h0 : psc_cnt_ff[i] + 3'h1; // see [R9]
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign chan2_is_output = is_out_ff[0];
  assign chan3_is_output = is_out_ff[1];
  assign chan2_capture_source = src_ff[0];
  assign chan3_capture_source = src_ff[1];
  assign chan2_capture = cap_ff[0];
  assign chan3_capture = cap_ff[1];

endmodule

// ---- core/mm_capture_pkg.sv ----
/*
  Package for the multi mode channel pair capture input block.
  Holds register offsets, field positions, mode codes and filter table.
  Assumes a 32-bit APB register bus and one timer kernel clock.
*/
package mm_capture_pkg;

  // Register map
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;

  // Field positions in the control register
  localparam int c2_ms_lo_pos = 0;
  localparam int c2_psc_pos = 2;
  localparam int c2_flt_pos = 4;
  localparam int c3_ms_lo_pos = 8;
  localparam int c3_psc_pos = 10;
  localparam int c3_flt_pos = 12;
  localparam int c2_ms_hi_pos = 30;
  localparam int c3_ms_hi_pos = 31;
  localparam logic [31:0] ctrl_rsvd_mask = 32'h3fff_0000;

  // Status register fields
  localparam int st_c2_lvl_pos = 0;
  localparam int st_c3_lvl_pos = 1;
  localparam int st_c2_out_pos = 2;
  localparam int st_c3_out_pos = 3;
  localparam int st_c2_cnt_pos = 4;
  localparam int st_c3_cnt_pos = 8;

  // Channel mode select codes
  typedef enum logic [2:0] {
    mode_output = 3'b000,
    mode_own_input = 3'b001,
    mode_neighbour_input = 3'b010,
    mode_internal_trigger = 3'b011,
    mode_plain_input = 3'b100
  } chan_mode_e;

  // Sampling rate selectors
  localparam logic [2:0] rate_timer = 3'h0;
  localparam logic [2:0] rate_div2 = 3'h1;
  localparam logic [2:0] rate_div4 = 3'h2;
  localparam logic [2:0] rate_div8 = 3'h3;
  localparam logic [2:0] rate_div16 = 3'h4;
  localparam logic [2:0] rate_div32 = 3'h5;

  // Filter code to required count of equal samples
  function automatic logic [3:0] flt_count(input logic [3:0] code);
    unique case (code)
      4'h1: flt_count = 4'h2;
      4'h2: flt_count = 4'h4;
      4'h3, 4'h5, 4'h7, 4'h9, 4'hc, 4'hf: flt_count = 4'h8;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: flt_count = 4'h6;
      4'ha, 4'hd: flt_count = 4'h5;
      default: flt_count = 4'h1;
    endcase
  endfunction

  // Filter code to sampling rate selector
  function automatic logic [2:0] flt_rate(input logic [3:0] code);
    unique case (code)
      4'h4, 4'h5: flt_rate = rate_div2;
      4'h6, 4'h7: flt_rate = rate_div4;
      4'h8, 4'h9: flt_rate = rate_div8;
      4'ha, 4'hb, 4'hc: flt_rate = rate_div16;
      4'hd, 4'he, 4'hf: flt_rate = rate_div32;
      default: flt_rate = rate_timer;
    endcase
  endfunction

  // Prescaler code to edge-count mask (every 1, 2, 4, 8 edges)
  function automatic logic [2:0] psc_mask(input logic [1:0] code);
    unique case (code)
      2'b01: psc_mask = 3'h1;
      2'b10: psc_mask = 3'h3;
      2'b11: psc_mask = 3'h7;
      default: psc_mask = 3'h0;
    endcase
  endfunction

endpackage

// ---- sim/mm_capture_input_assertions.sv ----
/* Port checks for the multi mode capture input block.
   Assumes clk_en is held high and one pclk domain. */
`timescale 1ns/1ps
module mm_capture_input_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic chan2_enable_bit,
  input wire logic chan2_is_output,
  input wire logic chan2_capture_source,
  input wire logic chan2_capture,
  input wire logic chan3_is_output,
  input wire logic chan3_capture_source,
  input wire logic chan3_capture
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Bus answer timing
  a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_one: assert property (pready |=> !pready) else $error("ready held");
  // Capture pulses against source, mode and enable
  a_c2_pulse: assert property (chan2_capture |=> !chan2_capture) else $error("long capture");
  a_c2_out: assert property (chan2_is_output |-> !chan2_capture && !chan2_capture_source) else $error("output cap");
  a_c2_src: assert property ($rose(chan2_capture) |-> chan2_capture_source) else $error("source low");
  a_c2_en: assert property (chan2_capture |-> $past(chan2_enable_bit)) else $error("capture disabled");
  a_c3_out: assert property (chan3_is_output |-> !chan3_capture) else $error("output cap 3");
  a_c3_src: assert property (chan3_capture |-> chan3_capture_source ##1 !chan3_capture) else $error("cap 3");
endmodule
bind mm_capture_input mm_capture_input_assertions mm_capture_input_assertions_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .chan2_enable_bit(chan2_enable_bit),
  .chan2_is_output(chan2_is_output), .chan2_capture_source(chan2_capture_source), .chan2_capture(chan2_capture),
  .chan3_is_output(chan3_is_output), .chan3_capture_source(chan3_capture_source), .chan3_capture(chan3_capture));

// ---- sim/mm_pin_source.sv ----
/* Model of the pins and trigger feeding the block.
   The bench picks one source; the others rest low. */
`timescale 1ns/1ps
module mm_pin_source (
  input wire logic pclk,
  input wire logic [1:0] sel,
  input wire logic lvl,
  output logic [3:0] pins = 4'h0
);
  // Index 2 stands for the internal trigger
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      pins[i] <= (sel == 2'(i)) ? lvl : 1'b0;
    end
  end
endmodule

// ---- sim/tb.sv ----
/* Bench for the capture input block: registers, sources, filter, prescaler.
   Assumes a 50 MHz pclk and a single-cycle APB answer. */
`timescale 1ns/1ps
module tb;
  import mm_capture_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dts_tick = 0, lvl = 0, e2 = 0, e3 = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, is2, is3, src2, src3, cap2, cap3;
  logic [1:0] sel = 2'h0;
  logic [3:0] pins;
  int failures = 0, n_checks = 0, cyc = 0, n2 = 0, n3 = 0;
  mm_pin_source mm_pin_source_i (.pclk(pclk), .sel(sel), .lvl(lvl), .pins(pins));
  mm_capture_input mm_capture_input_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dts_tick(dts_tick), .chan2_raw_input(pins[0]), .chan3_raw_input(pins[1]),
    .plain_chan2_raw(pins[3]), .plain_chan3_raw(pins[3]), .internal_trigger_signal(pins[2]),
    .chan2_enable_bit(e2), .chan3_enable_bit(e3), .chan2_is_output(is2), .chan3_is_output(is3),
    .chan2_capture_source(src2), .chan3_capture_source(src3), .chan2_capture(cap2), .chan3_capture(cap3));
  initial forever #10 pclk = ~pclk;
  // Dead-time tick, capture counters and hang guard
  always @(posedge pclk) begin
    dts_tick <= ~dts_tick;
    n2 += (cap2 === 1'b1);
    n3 += (cap3 === 1'b1);
    cyc++;
    if (cyc == 40000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer; answer taken at the edge where ready is high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [31:0] cw(logic [2:0] m, logic [1:0] p, logic [3:0] f, int sh);
    return ({24'h0, f, p, m[1:0]} << sh) | (32'(m[2]) << (c2_ms_hi_pos + sh / 8));
  endfunction
  // Mode writes only while disabled
  task automatic cfg(logic [31:0] v);
    e2 <= 0;
    e3 <= 0;
    apb(1, ctrl_offset, v);
    e2 <= 1;
    e3 <= 1;
    n2 = 0;
    n3 = 0;
  endtask
  task automatic pulse(logic [1:0] s, int n, int h);
    sel <= s;
    repeat (n) begin
      lvl <= 1;
      repeat (h) @(posedge pclk);
      lvl <= 0;
      repeat (h) @(posedge pclk);
    end
    repeat (12) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(0, ctrl_offset, 0);
    chk(rd, ctrl_reset);
    chk(is2, 1);
    cfg(32'hc000_ffff);
    apb(0, ctrl_offset, 0);
    chk(rd, ~ctrl_rsvd_mask);
    apb(0, 8'h08, 0);
    chk(err, 1);
    chk(rd, 0);
  endtask
  task automatic t_lock();
    cfg(cw(1, 0, 0, 0) | cw(2, 0, 0, c3_ms_lo_pos));
    apb(1, ctrl_offset, cw(4, 0, 0, 0) | cw(4, 0, 0, c3_ms_lo_pos));
    apb(0, ctrl_offset, 0);
    chk(rd, cw(1, 0, 0, 0) | cw(2, 0, 0, c3_ms_lo_pos));
    // Own pin level reaches channel 2 and, through the neighbour path, channel 3
    sel <= 0;
    lvl <= 1;
    repeat (6) @(posedge pclk);
    chk(src2, 1);
    chk(src3, 1);
    lvl <= 0;
    repeat (6) @(posedge pclk);
    chk(src2, 0);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 8; m++) begin
      cfg(cw(3'(m), 0, 0, 0));
      pulse(m == 2 ? 2'd1 : m == 3 ? 2'd2 : m == 4 ? 2'd3 : 2'd0, 2, 4);
      chk(n2, (m inside {[1:4]}) ? 2 : 0);
      chk(is2, m == 0);
      chk(is3, 1);
    end
  endtask
  task automatic t_psc();
    for (int p = 0; p < 4; p++) begin
      cfg(cw(1, 2'(p), 0, 0) | cw(1, 2'(p), 0, c3_ms_lo_pos));
      pulse(0, 8, 4);
      pulse(1, 8, 4);
      chk(n2, 8 >> p);
      chk(n3, 8 >> p);
    end
    cfg(cw(1, 1, 0, 0));
    pulse(0, 1, 4);
    e2 <= 0;
    @(posedge pclk);
    e2 <= 1;
    pulse(0, 1, 4);
    chk(n2, 0);
  endtask
  // Glitch one sample short of the count, then a pulse that passes
  task automatic t_filter();
    for (int c = 1; c < 4; c++) begin
      cfg(cw(1, 0, 4'(c), 0));
      pulse(0, 1, (1 << c) - 1);
      chk(n2, 0);
      pulse(0, 1, (1 << c) + 2);
      chk(n2, 1);
    end
    // Six samples at dts/2: a sample every 4 cycles with dts_tick every other cycle
    cfg(cw(1, 0, 4'h4, 0));
    pulse(0, 1, 16);
    chk(n2, 0);
    pulse(0, 1, 40);
    chk(n2, 1);
    // Five samples at dts/32: a sample every 64 cycles
    cfg(cw(1, 0, 4'hd, 0));
    pulse(0, 1, 192);
    chk(n2, 0);
    pulse(0, 1, 512);
    chk(n2, 1);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_lock();
    t_modes();
    t_psc();
    t_filter();
    complete_run();
  end
endmodule
